// ---- lcgis_gate.sv ----
`timescale 1ns/100ps
module lcgis_gate (
	// Selected data inputs and enables
	input  wire logic [3:0] i_data_in,
	input  wire logic [7:0] i_sel,
	// Gate result
	output logic            o_gate
);
	logic [7:0] forms;

	always_comb begin
		for (int k = 0; k < 4; k++) begin
			forms[2*k+1] = i_data_in[k];
			forms[2*k]   = ~i_data_in[k];
		end
		o_gate = |(i_sel & forms);
	end

endmodule : lcgis_gate

// ---- lcgis_pkg.sv ----
// Functional notes
// - Gate 1 select holds, bits 7 to 0, input 4 true/inverted down to 1.
// - Gate 2 select uses the same eight-bit arrangement as gate 1.
// - Gate 3 select uses the same eight-bit arrangement as gate 1.
// - A select bit at 1 routes its form into the gate, at 0 it adds nothing.
// - Each data input has a true and an inverted form, each chosen per gate.
// - Select bits are read/write, start undefined, kept over other resets; here i_resetn clears them to 0.
// - Each data input is one cell source picked by a three-bit field.
// - Each gate output may be inverted by software before the cell.
package lcgis_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 8;
	localparam int SRC_N   = 16;
	localparam int DIN_N   = 4;
	localparam int GATE_N  = 3;
	localparam int FIELD_W = 3;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_GATE1_SEL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_GATE2_SEL = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_GATE3_SEL = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_SRC_LO    = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_SRC_HI    = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_GATE_INV  = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'h6;

	// ----------------------------------------
	// Field positions and masks
	// ----------------------------------------
	localparam int POS_FIELD_A = 0;
	localparam int POS_FIELD_B = 4;
	localparam int POS_STAT_GATE = 4;
	localparam logic [DATA_W-1:0] MASK_SRC = 8'h77;
	localparam logic [DATA_W-1:0] MASK_INV = 8'h07;

	// Source index of field value 0 for data inputs 1..4, one nibble each
	localparam logic [15:0] DATA_BASE = 16'hC840;

	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam logic [DATA_W-1:0] RST_SEL  = 8'h00;
	localparam logic [DATA_W-1:0] RST_SRC  = 8'h00;
	localparam logic [DATA_W-1:0] RST_INV  = 8'h00;
	localparam logic [DATA_W-1:0] RST_RD   = 8'h00;
	localparam logic [SRC_N-1:0]  RST_SYNC = 16'h0000;
	localparam logic [GATE_N-1:0] RST_GATE = 3'h0;

endpackage : lcgis_pkg

// ---- lcgis_properties.sv ----
`timescale 1ns/100ps
module lcgis_checker
	import lcgis_pkg::*;
(
	input wire logic              i_ref_clk,
	input wire logic              i_resetn,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic              i_wr_en,
	input wire logic              i_rd_en,
	input wire logic [DATA_W-1:0] o_rd_data,
	input wire logic [SRC_N-1:0]  i_cell_sources,
	input wire logic              o_gate_one_out,
	input wire logic              o_gate_two_out,
	input wire logic              o_gate_three_out,
	input wire logic [GATE_N-1:0] o_gate_applied
);
	// Shadow of selects and invert; delayed copies absorb output latency
	logic [3:0][7:0] sh, sd1, sd2;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sh <= '0;
			sd1 <= '0;
			sd2 <= '0;
		end else begin
			sd1 <= sh;
			sd2 <= sd1;
			if (i_wr_en && i_addr < OFS_SRC_LO)
				sh[i_addr[1:0]] <= i_wr_data;
			if (i_wr_en && i_addr == OFS_GATE_INV)
				sh[3] <= i_wr_data & MASK_INV;
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_wr_rd(logic [3:0] a);
		i_wr_en && i_addr == a ##1 i_rd_en && i_addr == a;
	endsequence
	property p_g1_rw; s_wr_rd(OFS_GATE1_SEL) |=> o_rd_data == $past(i_wr_data, 2);
	endproperty
	a_g1_rw: assert property (p_g1_rw) else $error("gate1 readback");
	property p_g2_rw; s_wr_rd(OFS_GATE2_SEL) |=> o_rd_data == $past(i_wr_data, 2);
	endproperty
	a_g2_rw: assert property (p_g2_rw) else $error("gate2 readback");
	property p_g3_rw; s_wr_rd(OFS_GATE3_SEL) |=> o_rd_data == $past(i_wr_data, 2);
	endproperty
	a_g3_rw: assert property (p_g3_rw) else $error("gate3 readback");
	property p_rd_idle; !$past(i_rd_en) |-> o_rd_data == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
	property p_g1_none; sd1[0] == 0 && sd2[0] == 0 |-> !o_gate_one_out;
	endproperty
	a_g1_none: assert property (p_g1_none) else $error("gate1 empty");
	property p_g1_pair; &sd1[0][1:0] && &sd2[0][1:0] |-> o_gate_one_out;
	endproperty
	a_g1_pair: assert property (p_g1_pair) else $error("gate1 pair");
	property p_g2_pair; &sd1[1][7:6] && &sd2[1][7:6] |-> o_gate_two_out;
	endproperty
	a_g2_pair: assert property (p_g2_pair) else $error("gate2 pair");
	property p_inv; sh[3] == sd1[3] |-> o_gate_applied ==
		({o_gate_three_out, o_gate_two_out, o_gate_one_out} ^ sd1[3][2:0]);
	endproperty
	a_inv: assert property (p_inv) else $error("gate invert");
endmodule : lcgis_checker

bind lcgis_top lcgis_checker chk_u (.i_ref_clk, .i_resetn, .i_addr,
	.i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_cell_sources,
	.o_gate_one_out, .o_gate_two_out, .o_gate_three_out, .o_gate_applied);

// ---- lcgis_tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	mismatches++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module lcgis_tb;
	import lcgis_pkg::*;
	logic              i_ref_clk = 0, i_resetn = 0, i_wr_en = 0, i_rd_en = 0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wr_data = '0, o_rd_data, sel, fm;
	logic [SRC_N-1:0]  i_cell_sources = '0, src;
	logic              o_gate_one_out, o_gate_two_out, o_gate_three_out;
	logic [GATE_N-1:0] o_gate_applied, rv, gv;
	int                mismatches = 0, comparisons = 0;
	assign gv = {o_gate_three_out, o_gate_two_out, o_gate_one_out};
	lcgis_top dut_u (.i_ref_clk, .i_resetn, .i_addr, .i_wr_data, .i_wr_en,
		.i_rd_en, .o_rd_data, .i_cell_sources, .o_gate_one_out,
		.o_gate_two_out, .o_gate_three_out, .o_gate_applied);
	initial forever #2.5 i_ref_clk = ~i_ref_clk;
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_en <= 1'b1;
		@(posedge i_ref_clk);
		i_wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd_en <= 1'b1;
		@(posedge i_ref_clk);
		i_rd_en <= 1'b0;
		#1;
		`CHK("rd_data", e, o_rd_data)
	endtask : rd
	// Read issued right behind the write, no idle cycle
	task automatic wrrd(input logic [3:0] a, input logic [7:0] d, e);
		wr(a, d);
		i_rd_en <= 1'b1;
		@(posedge i_ref_clk);
		i_rd_en <= 1'b0;
		#1;
		`CHK("readback", e, o_rd_data)
	endtask : wrrd
	// Source change needs sync plus output register before it shows
	task automatic drive(input logic [15:0] s);
		@(posedge i_ref_clk);
		i_cell_sources <= s;
		repeat (4) @(posedge i_ref_clk);
		#1;
	endtask : drive
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		mismatches++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		for (int a = 0; a < 3; a++) rd(4'(a), 8'h00);
		$display("test reset_values done");
		wrrd(OFS_GATE1_SEL, 8'hA5, 8'hA5);
		wrrd(OFS_GATE2_SEL, 8'h5A, 8'h5A);
		wrrd(OFS_GATE3_SEL, 8'hC3, 8'hC3);
		wrrd(OFS_GATE_INV, 8'hFF, 8'h07);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		rd(OFS_GATE2_SEL, 8'h5A);
		$display("test register_access done");
		for (int g = 0; g < 3; g++) wr(4'(g), 8'h00);
		for (int g = 0; g < 3; g++) begin
			for (int k = 0; k < 11; k++) begin
				sel = k < 8 ? 8'h01 << k : k == 8 ? 8'h00 : k == 9 ? 8'h24 : 8'hC3;
				wr(4'(g), sel);
				wr(OFS_GATE_INV, 8'(k) & MASK_INV);
				for (int d = 0; d < 16; d++) begin
					// Other bits of each nibble oppose the wanted one
					for (int n = 0; n < 4; n++) src[4*n +: 4] = {{3{~d[n]}}, d[n]};
					drive(src);
					fm = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
					rv = 3'(|(sel & fm)) << g;
					`CHK("gate_raw", rv, gv)
					`CHK("gate_applied", rv ^ 3'(k), o_gate_applied)
					rd(OFS_STATUS, {1'b0, rv, 4'(d)});
				end
			end
			wr(4'(g), 8'h00);
		end
		$display("test gate_matrix done");
		for (int f = 0; f < 8; f++) begin
			wrrd(OFS_SRC_LO, 8'h88 | 8'(f * 17), 8'(f * 17));
			wrrd(OFS_SRC_HI, 8'h88 | 8'(f * 17), 8'(f * 17));
			for (int p = 0; p < 2; p++) begin
				src = p ? 16'h1E6B : 16'hE194;
				drive(src);
				fm = {4'h0, src[(12 + f) % 16], src[8 + f], src[4 + f], src[f]};
				rd(OFS_STATUS, fm);
			end
		end
		$display("test source_mux done");
		conclude();
	end
endmodule : lcgis_tb

// ---- lcgis_top.sv ----
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
module lcgis_top (
	// Clock and reset
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_resetn,
	// Register port
	input  wire logic [lcgis_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [lcgis_pkg::DATA_W-1:0]  i_wr_data,
	input  wire logic                          i_wr_en,
	input  wire logic                          i_rd_en,
	output logic      [lcgis_pkg::DATA_W-1:0]  o_rd_data,
	// Cell source signals
	input  wire logic [lcgis_pkg::SRC_N-1:0]   i_cell_sources,
	// Gate results
	output logic                               o_gate_one_out,
	output logic                               o_gate_two_out,
	output logic                               o_gate_three_out,
	output logic      [lcgis_pkg::GATE_N-1:0]  o_gate_applied
);
	import lcgis_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [DATA_W-1:0] gate1_source_select;
	logic [DATA_W-1:0] gate2_source_select;
	logic [DATA_W-1:0] gate3_source_select;
	logic [DATA_W-1:0] data_source_lo;
	logic [DATA_W-1:0] data_source_hi;
	logic [DATA_W-1:0] gate_invert;
	logic [DATA_W-1:0] rd_data;
	logic [DATA_W-1:0] next_gate1_source_select;
	logic [DATA_W-1:0] next_gate2_source_select;
	logic [DATA_W-1:0] next_gate3_source_select;
	logic [DATA_W-1:0] next_data_source_lo;
	logic [DATA_W-1:0] next_data_source_hi;
	logic [DATA_W-1:0] next_gate_invert;
	logic [DATA_W-1:0] next_rd_data;
	logic [DATA_W-1:0] status_word;

	logic [SRC_N-1:0]  src_meta;
	logic [SRC_N-1:0]  src_sync;

	logic [DIN_N-1:0]  cell_data_in;
	logic [GATE_N-1:0] gate_raw;
	logic [GATE_N-1:0] gate_out;
	logic [GATE_N-1:0] gate_appl;
	logic [GATE_N-1:0] next_gate_out;
	logic [GATE_N-1:0] next_gate_appl;
	logic [GATE_N-1:0] gate_inv_en;
	logic [GATE_N-1:0][DATA_W-1:0] gate_sel_all;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Reserved source and invert bits are dropped so they read back 0
	always_comb begin
		next_gate1_source_select = gate1_source_select;
		next_gate2_source_select = gate2_source_select;
		next_gate3_source_select = gate3_source_select;
		next_data_source_lo      = data_source_lo;
		next_data_source_hi      = data_source_hi;
		next_gate_invert         = gate_invert;
		if (i_wr_en) begin
			case (i_addr)
				OFS_GATE1_SEL: next_gate1_source_select = i_wr_data;
				OFS_GATE2_SEL: next_gate2_source_select = i_wr_data;
				OFS_GATE3_SEL: next_gate3_source_select = i_wr_data;
				OFS_SRC_LO:    next_data_source_lo = i_wr_data & MASK_SRC;
				OFS_SRC_HI:    next_data_source_hi = i_wr_data & MASK_SRC;
				OFS_GATE_INV:  next_gate_invert = i_wr_data & MASK_INV;
				default: begin
				end
			endcase
		end
	end

	// Select contents are undefined at power-up; zero chosen here
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			gate1_source_select <= RST_SEL;
			gate2_source_select <= RST_SEL;
			gate3_source_select <= RST_SEL;
			data_source_lo      <= RST_SRC;
			data_source_hi      <= RST_SRC;
			gate_invert         <= RST_INV;
		end else begin
			gate1_source_select <= next_gate1_source_select;
			gate2_source_select <= next_gate2_source_select;
			gate3_source_select <= next_gate3_source_select;
			data_source_lo      <= next_data_source_lo;
			data_source_hi      <= next_data_source_hi;
			gate_invert         <= next_gate_invert;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Status shows the gate results before inversion
	always_comb begin
		status_word                          = RST_RD;
		status_word[DIN_N-1:0]               = cell_data_in;
		status_word[POS_STAT_GATE +: GATE_N] = gate_out;
	end

	// Read data valid only in the cycle after the strobe
	always_comb begin
		next_rd_data = RST_RD;
		if (i_rd_en) begin
			case (i_addr)
				OFS_GATE1_SEL: next_rd_data = gate1_source_select;
				OFS_GATE2_SEL: next_rd_data = gate2_source_select;
				OFS_GATE3_SEL: next_rd_data = gate3_source_select;
				OFS_SRC_LO:    next_rd_data = data_source_lo;
				OFS_SRC_HI:    next_rd_data = data_source_hi;
				OFS_GATE_INV:  next_rd_data = gate_invert;
				OFS_STATUS: begin
					next_rd_data = status_word;
				end
				default:       next_rd_data = RST_RD;
			endcase
		end
	end

	// Cleared outside the answer cycle so stale data never lingers
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd_data <= RST_RD;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	assign o_rd_data = rd_data;

	// ----------------------------------------
	// Source synchroniser
	// ----------------------------------------
	// Sources may come from pins or other clocks
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			src_meta <= RST_SYNC;
			src_sync <= RST_SYNC;
		end else begin
			src_meta <= i_cell_sources;
			src_sync <= src_meta;
		end
	end

	// ----------------------------------------
	// Data input multiplexers
	// ----------------------------------------
	// Logic reads only the second synchroniser stage
	// Four-bit index wraps, so input 4 reaches sources 12..15 then 0..3
	always_comb begin
		logic [3:0]         idx;
		logic [FIELD_W-1:0] field;
		idx   = 4'h0;
		field = '0;
		for (int k = 0; k < DIN_N; k++) begin
			case (k)
				0:       field = data_source_lo[POS_FIELD_A +: FIELD_W];
				1:       field = data_source_lo[POS_FIELD_B +: FIELD_W];
				2:       field = data_source_hi[POS_FIELD_A +: FIELD_W];
				default: field = data_source_hi[POS_FIELD_B +: FIELD_W];
			endcase
			idx = DATA_BASE[k*4 +: 4] + {1'b0, field};
			cell_data_in[k] = src_sync[idx];
		end
	end

	// ----------------------------------------
	// Gates
	// ----------------------------------------
	assign gate_sel_all = {gate3_source_select,
	                       gate2_source_select,
	                       gate1_source_select};

	// Gate 1 sits at index 0, matching bit 0 of the invert register
	genvar g;
	generate
		for (g = 0; g < GATE_N; g++) begin : gen_gate
			lcgis_gate u_gate (
				.i_data_in (cell_data_in),
				.i_sel     (gate_sel_all[g]),
				.o_gate    (gate_raw[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Gate results
	// ----------------------------------------
	// Invert bits above gate 3 are masked on write
	assign gate_inv_en = gate_invert[GATE_N-1:0];

	always_comb begin
		next_gate_out  = gate_raw;
		next_gate_appl = gate_raw ^ gate_inv_en;
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			gate_out  <= RST_GATE;
			gate_appl <= RST_GATE;
		end else begin
			gate_out  <= next_gate_out;
			gate_appl <= next_gate_appl;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Raw results leave here; the inverted copy feeds the cell function
	assign o_gate_one_out   = gate_out[0];
	assign o_gate_two_out   = gate_out[1];
	assign o_gate_three_out = gate_out[2];
	assign o_gate_applied   = gate_appl;

endmodule : lcgis_top
